// ==== src/cmp_edge_pkg.sv ====
package cmp_edge_pkg;

    // ------------------------------------------------------------
    // register layouts and reset values
    // ------------------------------------------------------------
    localparam int NUM_CMP = 2;
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OUT_BIT = 6;
    localparam int CTRL_RISE_BIT = 5;
    localparam int CTRL_FALL_BIT = 4;
    localparam int CTRL_HYP_LSB = 2;
    localparam int CTRL_HYN_LSB = 0;
    localparam int MODE_RIE_BIT = 5;
    localparam int MODE_FIE_BIT = 4;
    localparam int MODE_MD_LSB = 0;
    localparam int MUX_NEG_LSB = 2;
    localparam int MUX_POS_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] HYST_RESET = 2'h0;
    localparam logic [1:0] MODE_RESET = 2'h2;
    localparam logic [1:0] MUX_SEL_RESET = 2'h0;
    localparam logic [1:0] HYST_OFF = 2'h0;

    // response time modes, fastest first
    typedef enum logic [1:0] {
        MODE_FASTEST = 2'h0,
        MODE_ONE = 2'h1,
        MODE_TWO = 2'h2,
        MODE_SLOWEST = 2'h3
    } resp_mode_e;

    // software write to one comparator's fields
    typedef struct packed {
        logic ctrl_we;
        logic mode_we;
        logic mux_we;
        logic [7:0] wdata;
    } cmp_write_s;

    // analog-side settings handed to one comparator core
    typedef struct packed {
        logic power_on;
        logic [1:0] pos_hyst_sel;
        logic [1:0] neg_hyst_sel;
        resp_mode_e response_mode;
        logic [1:0] pos_input_sel;
        logic [1:0] neg_input_sel;
    } cmp_analog_s;

endpackage : cmp_edge_pkg

// ==== src/cmp_sync_edge.sv ====
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser with edge detect on the second and third stage
module cmp_sync_edge
    import cmp_edge_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_raw,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // ------------------------------------------------------------
    // synchroniser; meta_q is read by sync_q only
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= i_raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edges compared only after both stages
    assign o_level = sync_q;
    assign o_rise = sync_q & ~prev_q;
    assign o_fall = ~sync_q & prev_q;
endmodule : cmp_sync_edge
`default_nettype wire

// ==== src/dual_comparator_edge_logic.sv ====
// Functional notes
// - two identical comparators, comparator0 may reset
// - latched synchronous and raw asynchronous outputs
// - raw output works without system clock
// - two-bit positive and negative input selects
// - disabled comparator drives low, powered down
// - writable response-time mode per comparator
// - separate positive and negative hysteresis fields
// - interrupts on rising and falling transitions
// - falling sets fall flag, rising sets rise
// - flags sticky until software clears them
// - output state bit readable any time
// - enable bit one on, zero off
// - spurious edges may set flags at power-up
// - per-edge interrupt enables gate requests
// - mode 00 fastest, 11 slowest
// - hysteresis 00 disables, others increase amount
// - state one when positive exceeds negative
`timescale 1ns/1ns
`default_nettype none
module dual_comparator_edge_logic
    import cmp_edge_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // analog core decisions: 1 when positive input exceeds negative
    input wire logic [NUM_CMP-1:0] i_cmp_decision,
    // software write strobes and data per comparator
    input wire cmp_write_s [NUM_CMP-1:0] i_cmp_write,
    // comparator0 reset source enable
    input wire logic i_cmp0_reset_src_en,
    output logic [7:0] o_cmp0_control_reg,
    output logic [7:0] o_cmp1_control_reg,
    output logic [7:0] o_cmp0_mode_reg,
    output logic [7:0] o_cmp1_mode_reg,
    output logic [7:0] o_cmp0_input_mux_reg,
    output logic [7:0] o_cmp1_input_mux_reg,
    output cmp_analog_s [NUM_CMP-1:0] o_cmp_analog,
    output logic o_cmp0_sync_out,
    output logic o_cmp1_sync_out,
    output logic o_cmp0_raw_out,
    output logic o_cmp1_raw_out,
    output logic [NUM_CMP-1:0] o_cmp_rise_irq,
    output logic [NUM_CMP-1:0] o_cmp_fall_irq,
    output logic o_cmp0_reset_req
);
    logic [NUM_CMP-1:0] cmp_enable_bit_q;
    logic [NUM_CMP-1:0] cmp_rise_flag_q;
    logic [NUM_CMP-1:0] cmp_fall_flag_q;
    logic [NUM_CMP-1:0] cmp_rise_irq_enable_q;
    logic [NUM_CMP-1:0] cmp_fall_irq_enable_q;
    logic [1:0] cmp_pos_hyst_sel_q [NUM_CMP];
    logic [1:0] cmp_neg_hyst_sel_q [NUM_CMP];
    resp_mode_e cmp_response_mode_q [NUM_CMP];
    logic [1:0] cmp_pos_input_sel_q [NUM_CMP];
    logic [1:0] cmp_neg_input_sel_q [NUM_CMP];
    logic [NUM_CMP-1:0] sync_level;
    logic [NUM_CMP-1:0] rise_evt;
    logic [NUM_CMP-1:0] fall_evt;
    logic [NUM_CMP-1:0] cmp_output_state;
    logic [NUM_CMP-1:0] sync_out_q;
    logic [NUM_CMP-1:0] rise_irq_q;
    logic [NUM_CMP-1:0] fall_irq_q;
    logic reset_req_q;
    logic [7:0] ctrl_view [NUM_CMP];
    logic [7:0] mode_view [NUM_CMP];
    logic [7:0] mux_view [NUM_CMP];
    logic [7:0] ctrl_q [NUM_CMP];
    logic [7:0] mode_q [NUM_CMP];
    logic [7:0] mux_q [NUM_CMP];

    // ------------------------------------------------------------
    // per-comparator logic, both instances alike
    // ------------------------------------------------------------
    genvar n;
    generate
        for (n = 0; n < NUM_CMP; n++) begin : g_cmp
            logic ctrl_we;
            logic mode_we;
            logic mux_we;
            logic [7:0] wd;
            logic gated_raw;
            logic rise_set;
            logic fall_set;
            logic rise_d;
            logic fall_d;

            assign ctrl_we = i_cmp_write[n].ctrl_we;
            assign mode_we = i_cmp_write[n].mode_we;
            assign mux_we = i_cmp_write[n].mux_we;
            assign wd = i_cmp_write[n].wdata;

            // a disabled comparator is powered down and reads low
            assign gated_raw = i_cmp_decision[n] & cmp_enable_bit_q[n];

            cmp_sync_edge u_sync (
                .i_ref_clk(i_ref_clk),
                .i_rst_n(i_rst_n),
                .i_raw(gated_raw),
                .o_level(sync_level[n]),
                .o_rise(rise_evt[n]),
                .o_fall(fall_evt[n])
            );

            // synchronised level so software never sees a metastable bit
            assign cmp_output_state[n] = sync_level[n];

            // power-up and setting changes can glitch the core; flags may catch it
            assign rise_set = rise_evt[n];
            assign fall_set = fall_evt[n];
            // set wins over a clear landing in the same cycle
            assign rise_d = rise_set | (ctrl_we ? wd[CTRL_RISE_BIT] : cmp_rise_flag_q[n]);
            assign fall_d = fall_set | (ctrl_we ? wd[CTRL_FALL_BIT] : cmp_fall_flag_q[n]);

            // register state; all writable fields load on their strobe
            always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    cmp_enable_bit_q[n] <= 1'b0;
                    cmp_rise_flag_q[n] <= 1'b0;
                    cmp_fall_flag_q[n] <= 1'b0;
                    cmp_rise_irq_enable_q[n] <= 1'b0;
                    cmp_fall_irq_enable_q[n] <= 1'b0;
                    cmp_pos_hyst_sel_q[n] <= HYST_RESET;
                    cmp_neg_hyst_sel_q[n] <= HYST_RESET;
                    cmp_response_mode_q[n] <= resp_mode_e'(MODE_RESET);
                    cmp_pos_input_sel_q[n] <= MUX_SEL_RESET;
                    cmp_neg_input_sel_q[n] <= MUX_SEL_RESET;
                end else begin
                    cmp_rise_flag_q[n] <= rise_d;
                    cmp_fall_flag_q[n] <= fall_d;
                    if (ctrl_we) begin
                        cmp_enable_bit_q[n] <= wd[CTRL_EN_BIT];
                        cmp_pos_hyst_sel_q[n] <= wd[CTRL_HYP_LSB +: 2];
                        cmp_neg_hyst_sel_q[n] <= wd[CTRL_HYN_LSB +: 2];
                    end
                    if (mode_we) begin
                        cmp_rise_irq_enable_q[n] <= wd[MODE_RIE_BIT];
                        cmp_fall_irq_enable_q[n] <= wd[MODE_FIE_BIT];
                        cmp_response_mode_q[n] <= resp_mode_e'(wd[MODE_MD_LSB +: 2]);
                    end
                    if (mux_we) begin
                        cmp_pos_input_sel_q[n] <= wd[MUX_POS_LSB +: 2];
                        cmp_neg_input_sel_q[n] <= wd[MUX_NEG_LSB +: 2];
                    end
                end
            end

            // readback images; unused bits read as zero
            always_comb begin
                ctrl_view[n] = CTRL_RESET;
                ctrl_view[n][CTRL_EN_BIT] = cmp_enable_bit_q[n];
                ctrl_view[n][CTRL_OUT_BIT] = cmp_output_state[n];
                ctrl_view[n][CTRL_RISE_BIT] = cmp_rise_flag_q[n];
                ctrl_view[n][CTRL_FALL_BIT] = cmp_fall_flag_q[n];
                ctrl_view[n][CTRL_HYP_LSB +: 2] = cmp_pos_hyst_sel_q[n];
                ctrl_view[n][CTRL_HYN_LSB +: 2] = cmp_neg_hyst_sel_q[n];
                mode_view[n] = 8'h00;
                mode_view[n][MODE_RIE_BIT] = cmp_rise_irq_enable_q[n];
                mode_view[n][MODE_FIE_BIT] = cmp_fall_irq_enable_q[n];
                mode_view[n][MODE_MD_LSB +: 2] = cmp_response_mode_q[n];
                mux_view[n] = 8'h00;
                mux_view[n][MUX_POS_LSB +: 2] = cmp_pos_input_sel_q[n];
                mux_view[n][MUX_NEG_LSB +: 2] = cmp_neg_input_sel_q[n];
            end

            // output flops: readbacks, analog settings, irqs, sync out
            always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    ctrl_q[n] <= CTRL_RESET;
                    mode_q[n] <= {6'h00, MODE_RESET};
                    mux_q[n] <= 8'h00;
                    sync_out_q[n] <= 1'b0;
                    rise_irq_q[n] <= 1'b0;
                    fall_irq_q[n] <= 1'b0;
                    o_cmp_analog[n] <= '0;
                end else begin
                    ctrl_q[n] <= ctrl_view[n];
                    mode_q[n] <= mode_view[n];
                    mux_q[n] <= mux_view[n];
                    sync_out_q[n] <= cmp_output_state[n];
                    rise_irq_q[n] <= cmp_rise_flag_q[n] & cmp_rise_irq_enable_q[n];
                    fall_irq_q[n] <= cmp_fall_flag_q[n] & cmp_fall_irq_enable_q[n];
                    o_cmp_analog[n] <= {cmp_enable_bit_q[n], cmp_pos_hyst_sel_q[n], cmp_neg_hyst_sel_q[n],
                        cmp_response_mode_q[n], cmp_pos_input_sel_q[n], cmp_neg_input_sel_q[n]};
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // comparator0 as reset source: low output requests reset
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reset_req_q <= 1'b0;
        end else begin
            reset_req_q <= i_cmp0_reset_src_en & cmp_enable_bit_q[0] & ~cmp_output_state[0];
        end
    end

    // raw outputs bypass every flop except the enable bit gate, so they run with the clock stopped;
    // this is the one deliberate exception to registered outputs
    assign o_cmp0_raw_out = i_cmp_decision[0] & cmp_enable_bit_q[0];
    assign o_cmp1_raw_out = i_cmp_decision[1] & cmp_enable_bit_q[1];

    assign o_cmp0_control_reg = ctrl_q[0];
    assign o_cmp1_control_reg = ctrl_q[1];
    assign o_cmp0_mode_reg = mode_q[0];
    assign o_cmp1_mode_reg = mode_q[1];
    assign o_cmp0_input_mux_reg = mux_q[0];
    assign o_cmp1_input_mux_reg = mux_q[1];
    assign o_cmp0_sync_out = sync_out_q[0];
    assign o_cmp1_sync_out = sync_out_q[1];
    assign o_cmp_rise_irq = rise_irq_q;
    assign o_cmp_fall_irq = fall_irq_q;
    assign o_cmp0_reset_req = reset_req_q;
endmodule : dual_comparator_edge_logic
`default_nettype wire

// ==== tb/dual_comparator_edge_logic_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
// ------
// port checker, comparator 0 only so it stays small
// ------
module dual_comparator_edge_logic_checker
    import cmp_edge_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [NUM_CMP-1:0] i_cmp_decision,
    input wire cmp_write_s [NUM_CMP-1:0] i_cmp_write,
    input wire logic i_cmp0_reset_src_en,
    input wire logic [7:0] o_cmp0_control_reg,
    input wire logic [7:0] o_cmp0_mode_reg,
    input wire logic o_cmp0_sync_out,
    input wire logic o_cmp0_raw_out,
    input wire logic [NUM_CMP-1:0] o_cmp_rise_irq,
    input wire logic o_cmp0_reset_req
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // readback enable lags the internal one, so windows below leave a cycle of slack
    wire logic en = o_cmp0_control_reg[7];
    wire logic clr_rise = i_cmp_write[0].ctrl_we && !i_cmp_write[0].wdata[5];
    // raw output high must mean decision high and, one readback later, enable set
    chk_raw_gated: assert property (o_cmp0_raw_out |-> i_cmp_decision[0] ##1 en)
        else $error("raw output high while decision low");
    chk_sync_high: assert property ((en && i_cmp_decision[0])[*5] |-> o_cmp0_sync_out)
        else $error("synchronous output missed a high decision");
    chk_sync_low: assert property ((!i_cmp_decision[0])[*5] |-> !o_cmp0_sync_out)
        else $error("synchronous output missed a low decision");
    chk_state_bit: assert property ((en && i_cmp_decision[0])[*6] |-> o_cmp0_control_reg[6])
        else $error("output state bit not set");
    chk_rise_sets: assert property ($rose(o_cmp0_sync_out) |=> o_cmp0_control_reg[5])
        else $error("rise flag not set");
    chk_fall_sets: assert property ($fell(o_cmp0_sync_out) |=> o_cmp0_control_reg[4])
        else $error("fall flag not set");
    chk_flag_sticky: assert property ($fell(o_cmp0_control_reg[5]) |-> $past(clr_rise, 2))
        else $error("rise flag cleared without a write");
    chk_irq_gate: assert property (o_cmp_rise_irq[0] == (o_cmp0_control_reg[5] && o_cmp0_mode_reg[5]))
        else $error("rise request does not match flag and enable");
    chk_reset_vals: assert property ($rose(i_rst_n) |-> o_cmp0_control_reg == 8'h00 && o_cmp0_mode_reg == 8'h02)
        else $error("registers not at reset values");
    chk_reset_req: assert property ((i_cmp0_reset_src_en && en && !i_cmp_decision[0])[*6] |-> o_cmp0_reset_req)
        else $error("reset request missing");
    cov_rise: cover property ($rose(o_cmp0_control_reg[5]));
    cov_fall: cover property ($rose(o_cmp0_control_reg[4]));
    cov_rreq: cover property ($rose(o_cmp0_reset_req));
endmodule : dual_comparator_edge_logic_checker
bind dual_comparator_edge_logic dual_comparator_edge_logic_checker u_chk (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_cmp_decision(i_cmp_decision), .i_cmp_write(i_cmp_write),
    .i_cmp0_reset_src_en(i_cmp0_reset_src_en), .o_cmp0_control_reg(o_cmp0_control_reg),
    .o_cmp0_mode_reg(o_cmp0_mode_reg), .o_cmp0_sync_out(o_cmp0_sync_out), .o_cmp0_raw_out(o_cmp0_raw_out),
    .o_cmp_rise_irq(o_cmp_rise_irq), .o_cmp0_reset_req(o_cmp0_reset_req));
`default_nettype wire

// ==== tb/dual_comparator_edge_logic_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
// ------
// self-checking bench
// ------
module dual_comparator_edge_logic_bench import cmp_edge_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] dec = 2'h0;
    cmp_write_s [1:0] wr_q = '0;
    logic src_en = 1'b0;
    logic [1:0][7:0] ctrl, modr, muxr;
    logic [1:0] sync, raw, rirq, firq;
    cmp_analog_s [1:0] ana;
    logic rreq;
    int mismatches = 0;
    int n_checks = 0;
    int seed = 31730;
    // 4 ns clock
    always #2 clk = ~clk;
    dual_comparator_edge_logic uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cmp_decision(dec),
        .i_cmp_write(wr_q), .i_cmp0_reset_src_en(src_en), .o_cmp0_control_reg(ctrl[0]),
        .o_cmp1_control_reg(ctrl[1]), .o_cmp0_mode_reg(modr[0]), .o_cmp1_mode_reg(modr[1]),
        .o_cmp0_input_mux_reg(muxr[0]), .o_cmp1_input_mux_reg(muxr[1]), .o_cmp_analog(ana),
        .o_cmp0_sync_out(sync[0]), .o_cmp1_sync_out(sync[1]), .o_cmp0_raw_out(raw[0]),
        .o_cmp1_raw_out(raw[1]), .o_cmp_rise_irq(rirq), .o_cmp_fall_irq(firq), .o_cmp0_reset_req(rreq));
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // sample just after the edge so the flops have landed
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // k: 0 control, 1 mode, 2 input mux; strobe lasts one cycle
    task automatic wr(int c, int k, logic [7:0] d);
        @(posedge clk);
        wr_q[c].ctrl_we <= (k == 0);
        wr_q[c].mode_we <= (k == 1);
        wr_q[c].mux_we <= (k == 2);
        wr_q[c].wdata <= d;
        @(posedge clk);
        wr_q[c] <= '0;
    endtask : wr
    task automatic setd(int c, logic v);
        @(posedge clk);
        dec[c] <= v;
    endtask : setd
    function automatic logic [7:0] exp_mode(logic [7:0] d);
        return {2'h0, d[5:4], 2'h0, d[1:0]};
    endfunction : exp_mode
    task automatic chk_reset();
        for (int c = 0; c < 2; c++) begin
            chk("control", 8'h00, ctrl[c]);
            chk("mode", 8'h02, modr[c]);
            chk("raw", 8'h00, {7'h0, raw[c]});
        end
    endtask : chk_reset
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    // main sequence, each comparator in turn
    initial begin
        logic [7:0] d;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        chk_reset();
        for (int c = 0; c < 2; c++) begin
            d = 8'($random(seed));
            wr(c, 2, d);
            tick(3);
            chk("input mux", {4'h0, d[3:0]}, muxr[c]);
            chk("input sel", {4'h0, d[3:0]}, {4'h0, ana[c].neg_input_sel, ana[c].pos_input_sel});
            for (int m = 0; m < 4; m++) begin
                d = 8'($random(seed));
                d[1:0] = 2'(m);
                wr(c, 1, d);
                tick(3);
                chk("mode", exp_mode(d), modr[c]);
                chk("response", {6'h0, d[1:0]}, {6'h0, ana[c].response_mode});
            end
            for (int h = 0; h < 4; h++) begin
                d = {4'hc, 2'(h), ~2'(h)};
                wr(c, 0, d);
                tick(3);
                chk("control", {4'h8, d[3:0]}, ctrl[c]);
                chk("hyst", {4'h0, d[3:0]}, {4'h0, ana[c].pos_hyst_sel, ana[c].neg_hyst_sel});
                chk("power", 8'h01, {7'h0, ana[c].power_on});
            end
            // only the falling enable set, so the rising request must stay quiet
            wr(c, 1, 8'h10);
            setd(c, 1'b1);
            tick(6);
            chk("rise", {4'he, d[3:0]}, ctrl[c]);
            chk("sync", 8'h01, {7'h0, sync[c]});
            chk("irq", 8'h00, {6'h0, firq[c], rirq[c]});
            setd(c, 1'b0);
            tick(6);
            chk("fall", {4'hb, d[3:0]}, ctrl[c]);
            chk("irq", 8'h02, {6'h0, firq[c], rirq[c]});
            // both enables on: both sticky flags now request
            wr(c, 1, 8'h30);
            tick(3);
            chk("irq", 8'h03, {6'h0, firq[c], rirq[c]});
            wr(c, 0, {4'h8, d[3:0]});
            tick(3);
            chk("clear", {4'h8, d[3:0]}, ctrl[c]);
            repeat (20) begin
                setd(c, 1'($random(seed)));
                #1;
                chk("raw", {7'h0, dec[c]}, {7'h0, raw[c]});
            end
            if (c == 0) begin
                setd(0, 1'b0);
                src_en <= 1'b1;
                tick(6);
                chk("reset request", 8'h01, {7'h0, rreq});
                setd(0, 1'b1);
                tick(6);
                chk("reset request", 8'h00, {7'h0, rreq});
            end
            wr(c, 0, 8'h00);
            setd(c, 1'b1);
            tick(6);
            chk("disabled", 8'h00, {6'h0, sync[c], raw[c]});
        end
        // second reset in mid-run with flags possibly set
        @(posedge clk);
        rst_n <= 1'b0;
        tick(4);
        chk_reset();
        @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        chk_reset();
        print_verdict();
    end
    // watchdog, well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
endmodule : dual_comparator_edge_logic_bench
`default_nettype wire
